// ### shared/sdc_pkg.sv
/*
 * Constants shared by the delay calibration block: register indices and
 * byte addresses, field positions, reset values, calibration tables and
 * the state encoding.
 * Assumes a 32-bit APB with word-aligned registers and a single clock.
 */
package sdc_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int APB_ADDR_W = 12;
	localparam logic [9:0] IDX_CONTROL = 10'h2b0;
	localparam logic [9:0] IDX_CONFIG = 10'h2b1;
	localparam logic [9:0] IDX_RESULT = 10'h2b2;
	localparam logic [9:0] IDX_MANUAL = 10'h2b5;
	localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_CONFIG = {IDX_CONFIG, 2'h0};
	localparam logic [11:0] ADDR_RESULT = {IDX_RESULT, 2'h0};
	localparam logic [11:0] ADDR_MANUAL = {IDX_MANUAL, 2'h0};

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_FAIL_BIT = 1;
	localparam int CFG_HDUR_LSB = 0;
	localparam int CFG_AVG_LSB = 2;
	localparam int RES_DONE_BIT = 17;
	localparam int DELAY_W = 17;
	localparam int DELAY_INV_BIT = 16;
	localparam logic [3:0] CONFIG_RESET = 4'h5;
	localparam logic [16:0] DELAY_RESET = 17'h0_0000;

	// ------------------------------------------------------------------
	// Calibration tables
	// ------------------------------------------------------------------
	// Longest SYSREF period per accumulation code, in sampling clocks.
	localparam logic [3:0][15:0] PERIOD_LIMIT = {
		16'h544c, 16'h1450, 16'h044c, 16'h0055
	};
	// Base of the longest calibration time, 256 times 19 clocks.
	localparam int CAL_BASE_CYCLES = 256 * 19;
	localparam logic [8:0] COUNT_ONE = 9'h001;
	localparam logic [7:0] PHASE_ONE = 8'h01;

	// ------------------------------------------------------------------
	// Calibration sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		SDC_IDLE = 5'b00001,
		SDC_ARM = 5'b00010,
		SDC_MEASURE = 5'b00100,
		SDC_DONE = 5'b01000,
		SDC_FAIL = 5'b10000
	} sdc_fsm_e;

endpackage

// ### logic/sdc_sysref_sampler.sv
/*
 * SYSREF sampler: brings the SYSREF pin into the pclk domain, marks each
 * rising edge with a one-cycle pulse and flags a period longer than the
 * limit it is given.
 * Assumes SYSREF is asynchronous to pclk and much slower than it.
 */
module sdc_sysref_sampler (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// SYSREF pin.
	input wire logic sysref,
	// Period limit and results.
	input wire logic [15:0] period_limit,
	output logic sysref_rise,
	output logic period_overrun
);

	typedef struct packed {
		logic sync_a;
		logic sync_b;
		logic prev;
		logic [15:0] period;
		logic rise;
		logic overrun;
	} sdc_sampler_s;

	sdc_sampler_s st;
	sdc_sampler_s next_st;

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	// Only the second stage looks at the first, so no logic ever sees a
	// metastable level.
	always_comb begin
		next_st = st;
		next_st.sync_a = sysref;
		next_st.sync_b = st.sync_a;
		next_st.prev = st.sync_b;
		next_st.rise = st.sync_b & ~st.prev;
		if (st.sync_b & ~st.prev) begin
			next_st.period = 16'h0000;
		end else if (st.period != 16'hffff) begin
			next_st.period = st.period + 16'h0001;
		end
		next_st.overrun = st.period > period_limit;
	end

	// Registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sysref_rise = st.rise;
	assign period_overrun = st.overrun;

endmodule

// ### logic/sdc_top.sv
/*
 * SYSREF delay calibration with APB register access: register decode,
 * calibration sequencer and the registered clock delay output.
 * Assumes pclk is the sampling clock domain and SYSREF arrives on a pin.
 */
// Overview of operation
// - Enable low: delay follows the manual register; no calibration runs.
// - Enable high: delay holds until calibration completes, then takes its result; manual register ignored.
// - Calibration starts only on a 0-to-1 change of the enable bit.
// - Averaging code 0..3 selects 4, 16, 64 or 256 averages.
// - Accumulation code 0..3 selects 4, 16, 64 or 256 clocks each.
// - SYSREF period above 85/1100/5200/21580 clocks makes calibration fail.
// - Calibration ends within 256*19*4^(avg+acc+2) clocks.
// - Complete bit reads 1 only when enabled and calibration finished.
// - Result bits 16..0 hold computed delay, valid only when complete.
// - Configuration resets to 0x05; result contents reset to zero.
// - Delay: bit 16 inverts clock, 15..8 coarse, 7..0 fine.
module sdc_top #(
	parameter int MAX_CAL_BASE = sdc_pkg::CAL_BASE_CYCLES
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// SYSREF pin.
	input wire logic sysref,
	// Sampling clock delay control.
	output logic [16:0] clock_delay,
	output logic delay_cal_complete
);

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	// All state sits in one packed struct; next_st is its combinational copy.
	// Keeping it whole makes the register stage a single assignment.
	typedef struct packed {
		sdc_pkg::sdc_fsm_e fsm;
		logic delay_cal_enable;
		logic enable_prev;
		logic cal_fail;
		logic [1:0] average_count_select;
		logic [1:0] accumulation_length_select;
		logic [1:0] run_avg;
		logic [1:0] run_acc;
		logic [16:0] manual_delay_setting;
		logic [16:0] computed_delay_value;
		logic done;
		logic [7:0] window;
		logic [8:0] samples;
		logic [15:0] phase_sum;
		logic [31:0] watchdog;
		logic [16:0] delay_out;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} sdc_state_s;

	sdc_state_s st;
	sdc_state_s next_st;

	// Sampler pulses, registered in the sampler; decoded settings and handshake terms, combinational.
	logic sysref_rise;
	logic period_overrun;
	logic [15:0] period_limit;
	logic [8:0] window_len;
	logic [8:0] sample_len;
	logic [4:0] sum_shift;
	logic [31:0] cal_budget;
	logic [23:0] scaled_sum;
	logic wr_done;
	logic rd_phase;
	logic start;

	// -----------------------------------------------------------------
	// SYSREF capture
	// -----------------------------------------------------------------
	// The rise pulse comes about three clocks after the pin edge; that
	// latency shifts every phase equally, so the average moves by that same offset.
	sdc_sysref_sampler u_sampler (
		.pclk(pclk),
		.presetn(presetn),
		.sysref(sysref),
		.period_limit(period_limit),
		.sysref_rise(sysref_rise),
		.period_overrun(period_overrun)
	);

	// -----------------------------------------------------------------
	// Settings decoded from the latched configuration
	// -----------------------------------------------------------------
	// The running codes are frozen at start, so a configuration write in
	// mid-calibration cannot change the window or the count halfway.
	always_comb begin
		period_limit = sdc_pkg::PERIOD_LIMIT[st.run_acc];
		window_len = 9'h004 << {st.run_acc, 1'b0};
		sample_len = 9'h004 << {st.run_avg, 1'b0};
		sum_shift = 5'({st.run_avg, 1'b0}) + 5'h02;
		// Four bits hold avg+acc+2 up to eight; three would wrap at eight.
		cal_budget = 32'(MAX_CAL_BASE)
			<< {4'({2'b00, st.run_avg} + {2'b00, st.run_acc}) + 4'h2,
			1'b0};
		scaled_sum = {st.phase_sum, 8'h00} >> sum_shift;
	end

	// APB handshake terms: the access completes one cycle after penable.
	// One fixed wait state gives the read mux a full cycle to settle.
	assign rd_phase = psel & penable & ~st.pready;
	assign wr_done = psel & penable & st.pready & pwrite;
	assign start = st.delay_cal_enable & ~st.enable_prev;

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.enable_prev = st.delay_cal_enable;

		// Register writes take effect at the completing edge.
		next_st.pready = rd_phase;
		next_st.pslverr = 1'b0;
		if (wr_done) begin
			unique case (paddr)
				sdc_pkg::ADDR_CONTROL: begin
					next_st.delay_cal_enable =
						pwdata[sdc_pkg::CTRL_EN_BIT];
				end
				sdc_pkg::ADDR_CONFIG: begin
					next_st.average_count_select =
						pwdata[sdc_pkg::CFG_AVG_LSB +: 2];
					next_st.accumulation_length_select =
						pwdata[sdc_pkg::CFG_HDUR_LSB +: 2];
				end
				sdc_pkg::ADDR_MANUAL: begin
					next_st.manual_delay_setting =
						pwdata[sdc_pkg::DELAY_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Read data and error are prepared in the first access cycle.
		if (rd_phase) begin
			next_st.prdata = 32'h0000_0000;
			unique case (paddr)
				sdc_pkg::ADDR_CONTROL: begin
					next_st.prdata[sdc_pkg::CTRL_EN_BIT] =
						st.delay_cal_enable;
					next_st.prdata[sdc_pkg::CTRL_FAIL_BIT] = st.cal_fail;
				end
				sdc_pkg::ADDR_CONFIG: begin
					next_st.prdata[sdc_pkg::CFG_AVG_LSB +: 2] =
						st.average_count_select;
					next_st.prdata[sdc_pkg::CFG_HDUR_LSB +: 2] =
						st.accumulation_length_select;
				end
				sdc_pkg::ADDR_RESULT: begin
					next_st.prdata[sdc_pkg::DELAY_W-1:0] =
						st.computed_delay_value;
					next_st.prdata[sdc_pkg::RES_DONE_BIT] =
						st.done & st.delay_cal_enable;
				end
				sdc_pkg::ADDR_MANUAL: begin
					next_st.prdata[sdc_pkg::DELAY_W-1:0] =
						st.manual_delay_setting;
				end
				default: begin
					next_st.pslverr = 1'b1;
				end
			endcase
		end

		// Free-running accumulation window; SYSREF phase is its count.
		if ({1'b0, st.window} + COUNT_ONE_W() >= window_len) begin
			next_st.window = 8'h00;
		end else begin
			next_st.window = st.window + sdc_pkg::PHASE_ONE;
		end

		// Calibration sequencer.
		unique case (st.fsm)
			sdc_pkg::SDC_IDLE: begin
			end
			sdc_pkg::SDC_ARM: begin
				// The period counter may be stale here, so only the
				// watchdog can fail the wait for the first edge.
				next_st.watchdog = st.watchdog + 32'h0000_0001;
				if (sysref_rise) begin
					next_st.fsm = sdc_pkg::SDC_MEASURE;
				end
			end
			sdc_pkg::SDC_MEASURE: begin
				next_st.watchdog = st.watchdog + 32'h0000_0001;
				if (period_overrun) begin
					next_st.fsm = sdc_pkg::SDC_FAIL;
				end else if (sysref_rise) begin
					next_st.phase_sum = st.phase_sum
						+ {8'h00, st.window};
					next_st.samples = st.samples + sdc_pkg::COUNT_ONE;
					if (st.samples + sdc_pkg::COUNT_ONE == sample_len) begin
						next_st.fsm = sdc_pkg::SDC_DONE;
					end
				end
			end
			sdc_pkg::SDC_DONE: begin
			end
			sdc_pkg::SDC_FAIL: begin
			end
			default: begin
				next_st.fsm = sdc_pkg::SDC_IDLE;
			end
		endcase

		// Overtime check ends any calibration still running.
		// The budget counts from the start, not from the first SYSREF
		// edge, so a SYSREF that never arrives also ends the run.
		if ((st.fsm == sdc_pkg::SDC_ARM || st.fsm == sdc_pkg::SDC_MEASURE)
			&& st.watchdog >= cal_budget) begin
			next_st.fsm = sdc_pkg::SDC_FAIL;
		end

		// Completion: average phase lands in coarse and fine, no invert.
		if (st.fsm == sdc_pkg::SDC_MEASURE
			&& next_st.fsm == sdc_pkg::SDC_DONE) begin
			next_st.computed_delay_value = {1'b0, scaled_sum[15:0]};
			next_st.done = 1'b1;
		end
		if (next_st.fsm == sdc_pkg::SDC_FAIL) begin
			next_st.cal_fail = 1'b1;
		end

		// A rising enable restarts from scratch, even mid-run.
		if (start) begin
			next_st.fsm = sdc_pkg::SDC_ARM;
			next_st.run_avg = st.average_count_select;
			next_st.run_acc = st.accumulation_length_select;
			next_st.samples = 9'h000;
			next_st.phase_sum = 16'h0000;
			next_st.watchdog = 32'h0000_0000;
			next_st.done = 1'b0;
			next_st.cal_fail = 1'b0;
		end
		if (!st.delay_cal_enable) begin
			next_st.fsm = sdc_pkg::SDC_IDLE;
			next_st.done = 1'b0;
		end

		// Delay output: manual when disabled, calibrated once complete.
		// Between start and completion it holds, so a restart keeps the
		// manual setting loaded while enable was low before it.
		if (!st.delay_cal_enable) begin
			next_st.delay_out = st.manual_delay_setting;
		end else if (st.done) begin
			next_st.delay_out = st.computed_delay_value;
		end
	end

	// Width helper so the window compare stays at nine bits.
	function automatic logic [8:0] COUNT_ONE_W();
		return sdc_pkg::COUNT_ONE;
	endfunction

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	// Only constants load in reset; the result clears to zero so that a
	// read before any calibration returns a known value.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.fsm <= sdc_pkg::SDC_IDLE;
			st.average_count_select <=
				sdc_pkg::CONFIG_RESET[sdc_pkg::CFG_AVG_LSB +: 2];
			st.accumulation_length_select <=
				sdc_pkg::CONFIG_RESET[sdc_pkg::CFG_HDUR_LSB +: 2];
			st.manual_delay_setting <= sdc_pkg::DELAY_RESET;
			st.delay_out <= sdc_pkg::DELAY_RESET;
		end else begin
			st <= next_st;
		end
	end

	// -----------------------------------------------------------------
	// Outputs, all straight from the state register
	// -----------------------------------------------------------------
	// No output passes through logic, so none can glitch on a bus edge.
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign clock_delay = st.delay_out;
	assign delay_cal_complete = st.done;

endmodule

// ### verification/sdc_asserts.sv
/*
 * Checker for the delay calibration block: APB timing, map decoding,
 * completion flag and delay output source.
 * Assumes it is bound to sdc_top and sees only that module's ports.
 */
module sdc_asserts #(
	parameter int MAX_CAL_BASE = 4864
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// SYSREF and delay.
	input wire logic sysref,
	input wire logic [16:0] clock_delay,
	input wire logic delay_cal_complete
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// Shadow of the enable and manual registers
	// ----------------------------------------------------------------
	logic wr;
	logic mapped;
	logic en_m;
	logic [16:0] man_m;
	logic [1:0] quiet;

	// A completed write to a mapped register.
	assign wr = psel && penable && pready && pwrite && !pslverr;
	assign mapped = paddr == sdc_pkg::ADDR_CONTROL ||
		paddr == sdc_pkg::ADDR_CONFIG || paddr == sdc_pkg::ADDR_RESULT ||
		paddr == sdc_pkg::ADDR_MANUAL;

	// Quiet counts settled cycles, since outputs lag writes by two.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_m <= 1'b0;
			man_m <= 17'h0_0000;
			quiet <= 2'h0;
		end else begin
			if (wr && paddr == sdc_pkg::ADDR_CONTROL)
				en_m <= pwdata[0];
			if (wr && paddr == sdc_pkg::ADDR_MANUAL)
				man_m <= pwdata[16:0];
			quiet <= wr ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence s_wait;
		psel && penable && !pready;
	endsequence

	one_wait_a: assert property (s_wait |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	slverr_map_a: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr does not match decode");
	unmapped_zero_a: assert property (pready && !pwrite && !mapped |->
		prdata == 32'h0000_0000) else $error("unmapped read not zero");
	cfg_read_a: assert property (pready && !pwrite && paddr ==
		sdc_pkg::ADDR_CONFIG |-> prdata[31:4] == 28'h000_0000)
		else $error("config reserved bits set");
	res_read_a: assert property (pready && !pwrite && paddr ==
		sdc_pkg::ADDR_RESULT |-> prdata[31:18] == 14'h0000)
		else $error("result reserved bits set");
	done_needs_en_a: assert property (!en_m |=> !delay_cal_complete)
		else $error("complete while disabled");
	manual_follow_a: assert property (quiet == 2'h3 && !en_m |->
		clock_delay == man_m) else $error("delay not manual");
	rise_start_a: assert property ($rose(en_m) |=>
		!delay_cal_complete [*3]) else $error("complete too early");
	hold_result_a: assert property ($past(delay_cal_complete, 2) &&
		delay_cal_complete |-> $stable(clock_delay))
		else $error("delay moved while complete");
endmodule

bind sdc_top sdc_asserts #(.MAX_CAL_BASE(MAX_CAL_BASE)) u_sdc_asserts (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sysref(sysref),
	.clock_delay(clock_delay), .delay_cal_complete(delay_cal_complete)
);

// ### verification/sdc_top_bench.sv
/*
 * Self-checking bench for sdc_top: register access, manual delay,
 * calibration for every code, restart and overrun failure.
 * Assumes the checker file is compiled alongside.
 */
module sdc_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, sysref, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [16:0] clock_delay, cal;
	logic delay_cal_complete;
	int error_cnt = 0;
	int check_count = 0;
	int sr_period = 0;

	// A short overtime base, 19 clocks instead of 256 times 19, lets the
	// overtime path run in a few hundred cycles; every calibration fits.
	localparam int CAL_BASE_SIM = 19;

	sdc_top #(.MAX_CAL_BASE(CAL_BASE_SIM)) u_sdc_top (.pclk(pclk),
		.presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sysref(sysref),
		.clock_delay(clock_delay), .delay_cal_complete(delay_cal_complete));

	// ----------------------------------------------------------------
	// Clock and SYSREF source
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// SYSREF stands low while the period is zero.
	initial begin
		sysref = 1'b0;
		forever begin
			@(posedge pclk);
			if (sr_period > 0) begin
				sysref <= 1'b1;
				repeat (sr_period / 2) @(posedge pclk);
				sysref <= 1'b0;
				repeat (sr_period - sr_period / 2 - 1) @(posedge pclk);
			end
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task check(input string what, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask

	// One APB transfer; read data lands in rd, the error flag in err.
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20)
			check("pready", 32'h0000_0001, 32'h0000_0000);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task close_out;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		apb(sdc_pkg::ADDR_CONFIG, 1'b0, 32'h0000_0000);
		check("config reset", 32'h0000_0005, rd);
		apb(sdc_pkg::ADDR_CONTROL, 1'b0, 32'h0000_0000);
		check("control reset", 32'h0000_0000, rd);
		apb(12'h000, 1'b0, 32'h0000_0000);
		check("unmapped error", 32'h0000_0001, {31'h0, err});
		apb(sdc_pkg::ADDR_CONFIG, 1'b1, 32'h0000_00ff);
		apb(sdc_pkg::ADDR_CONFIG, 1'b0, 32'h0000_0000);
		check("config fields", 32'h0000_000f, rd);
		apb(sdc_pkg::ADDR_RESULT, 1'b1, 32'h0003_ffff);
		apb(sdc_pkg::ADDR_RESULT, 1'b0, 32'h0000_0000);
		check("result read only", 32'h0000_0000, rd);
	endtask

	task t_manual;
		apb(sdc_pkg::ADDR_MANUAL, 1'b1, 32'h0001_2345);
		repeat (3) @(posedge pclk);
		check("manual delay", 32'h0001_2345, {15'h0, clock_delay});
		check("complete idle", 32'h0, {31'h0, delay_cal_complete});
	endtask

	// Calibrate with the given codes; complete needs 4^(avg+1) more rises.
	task t_cal(input int avg, input int acc, input int period);
		int cyc, edges;
		logic ok;
		cyc = 0;
		edges = 4 ** (avg + 1);
		sr_period = period;
		apb(sdc_pkg::ADDR_CONFIG, 1'b1, 32'(avg * 4 + acc));
		// No converter calibration exists here, so enable may follow.
		apb(sdc_pkg::ADDR_CONTROL, 1'b1, 32'h0000_0001);
		while (delay_cal_complete !== 1'b1 && cyc < 8000) begin
			@(posedge pclk);
			cyc++;
		end
		ok = cyc >= edges * period && cyc <= (edges + 2) * period + 10 &&
			cyc <= 256 * 19 * 4 ** (avg + acc + 2);
		check("cal time", 32'h0000_0001, {31'h0, ok});
		repeat (2) @(posedge pclk);
		apb(sdc_pkg::ADDR_RESULT, 1'b0, 32'h0000_0000);
		cal = rd[16:0];
		check("done bit", 32'h0000_0001, {17'h0_0000, rd[31:17]});
		check("invert bit", 32'h0000_0000, {31'h0, rd[16]});
		check("delay applied", {15'h0, cal}, {15'h0, clock_delay});
		apb(sdc_pkg::ADDR_CONTROL, 1'b1, 32'h0000_0001);
		apb(sdc_pkg::ADDR_MANUAL, 1'b1, 32'h0000_0a5a);
		repeat (3) @(posedge pclk);
		check("no restart", 32'h1, {31'h0, delay_cal_complete});
		check("manual ignored", {15'h0, cal}, {15'h0, clock_delay});
		apb(sdc_pkg::ADDR_CONTROL, 1'b1, 32'h0000_0000);
		repeat (3) @(posedge pclk);
		check("done cleared", 32'h0, {31'h0, delay_cal_complete});
		check("manual back", 32'h0000_0a5a, {15'h0, clock_delay});
	endtask

	// A period above 85 clocks with accumulation code 0 must fail; the
	// averaging code 1 puts the overtime budget well beyond the wait.
	task t_fail;
		sr_period = 120;
		apb(sdc_pkg::ADDR_CONFIG, 1'b1, 32'h0000_0004);
		apb(sdc_pkg::ADDR_CONTROL, 1'b1, 32'h0000_0001);
		repeat (500) @(posedge pclk);
		apb(sdc_pkg::ADDR_CONTROL, 1'b0, 32'h0000_0000);
		check("overrun fail", 32'h0000_0003, rd);
		check("no complete", 32'h0, {31'h0, delay_cal_complete});
		apb(sdc_pkg::ADDR_CONTROL, 1'b1, 32'h0000_0000);
		sr_period = 0;
	endtask

	// With SYSREF stopped only the budget, 19 times 16 clocks, ends it.
	task t_budget;
		repeat (130) @(posedge pclk);
		apb(sdc_pkg::ADDR_CONFIG, 1'b1, 32'h0000_0000);
		apb(sdc_pkg::ADDR_CONTROL, 1'b1, 32'h0000_0001);
		repeat (250) @(posedge pclk);
		apb(sdc_pkg::ADDR_CONTROL, 1'b0, 32'h0000_0000);
		check("within budget", 32'h0000_0001, rd);
		repeat (150) @(posedge pclk);
		apb(sdc_pkg::ADDR_CONTROL, 1'b0, 32'h0000_0000);
		check("budget fail", 32'h0000_0003, rd);
		apb(sdc_pkg::ADDR_CONTROL, 1'b1, 32'h0000_0000);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_manual();
		for (int i = 0; i < 4; i++)
			t_cal(i, i, 20);
		t_fail();
		t_budget();
		close_out();
	end

	// The tests need about 8000 cycles; five times that is a hang.
	initial begin
		repeat (40000) @(posedge pclk);
		error_cnt++;
		close_out();
	end
endmodule
